/* logic/eep_pkg.sv */
// Shared constants and types for the two-wire EEPROM client and its host.
`default_nettype none
package eep_pkg;
  localparam int ADDR_W = 12;
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_W = 5;
  localparam logic [3:0] DEV_CODE = 4'ha;
  localparam logic [11:0] PROT_BASE = 12'hc00;
  localparam logic [11:0] ADDR_RST = 12'h000;
  localparam int CLK_MHZ = 125;
  localparam int WRITE_CYCLE_US = 5;
  localparam int WRITE_CYCLES = WRITE_CYCLE_US * CLK_MHZ;
  localparam int SCL_HALF = 4;
  localparam int SAMPLE_BITS = 1;
  typedef enum logic [1:0] {
    EEP_CMD_WRITE,
    EEP_CMD_SET_ADDR,
    EEP_CMD_READ_CUR
  } eep_cmd_t;
endpackage
`default_nettype wire

/* logic/eep_link_if.sv */
// Two-wire link between the EEPROM client and its host.
`default_nettype none
interface eep_link_if;
  logic scl_o;
  logic sda_host_oe_n;
  logic sda_dev_oe_n;
  logic sda;
  assign sda = ~sda_host_oe_n ? 1'b0 : (~sda_dev_oe_n ? 1'b0 : 1'b1);
  modport dev (
    input scl_o,
    input sda,
    output sda_dev_oe_n
  );
  modport host (
    output scl_o,
    input sda,
    output sda_host_oe_n
  );
endinterface
`default_nettype wire

/* logic/eep_buf2.sv */
// Two-entry valid/ready buffer.
`default_nettype none
module eep_buf2 #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_r [2];
  logic [WIDTH-1:0] mem_nxt [2];
  logic rd_r, rd_nxt, wr_r, wr_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic push, pop;

  always_comb begin
    push = in_valid && (cnt_r != 2'h2);
    pop = out_ready && (cnt_r != 2'h0);
    mem_nxt = mem_r;
    if (push) begin
      mem_nxt[wr_r] = in_data;
    end
    wr_nxt = push ? ~wr_r : wr_r;
    rd_nxt = pop ? ~rd_r : rd_r;
    cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      mem_r[0] <= '0;
      mem_r[1] <= '0;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      mem_r <= mem_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign in_ready = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data = mem_r[rd_r];
endmodule
`default_nettype wire

/* logic/eep_client.sv */
// EEPROM client end: bus decoding, page buffer, protection and write cycle.
`default_nettype none
// Contract
// - Up to 32 page bytes, committed at Stop
// - Low five pointer bits count received bytes
// - Upper seven address bits stay fixed
// - Over 32 bytes wraps and overwrites buffer
// - Programming starts only at write Stop
// - Protected write acked, skipped, ready at once
// - Page writes wrap within aligned page
// - Protect high blocks C00h to FFFh
// - Protect latched at Stop only
// - No ack of write control while busy
// - Host polls by repeating Start and control
// - Direction bit one selects a read
// - Current read returns byte after last
// - No host ack ends read, line released
// - Random read loads pointer, no programming
// - Pointer follows byte returned by read
// - Host ack requests next sequential byte
// - Read pointer wraps FFF to 000
// - Host splits writes at page boundaries; eep_host sends every byte unsplit
// - Respond only to device code 1010
// - Chip-select bits must match select inputs
// - Address high byte first, low twelve bits
module eep_client #(
  parameter int WRITE_CYCLES = eep_pkg::WRITE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  eep_link_if.dev link,
  input wire logic chip_select_bit_two,
  input wire logic chip_select_bit_one,
  input wire logic chip_select_bit_zero,
  input wire logic wp_in,
  output logic busy,
  output logic [11:0] addr_ptr
);
  if (WRITE_CYCLES < 1) begin : g_bad_cycles
    $error("WRITE_CYCLES must be at least one");
  end

  // ****************************************
  // Input synchronisers and condition detect
  // ****************************************
  logic [1:0] scl_s_r, sda_s_r, wp_s_r, cs_s_r [3];
  logic scl_d_r, sda_d_r;
  logic scl_rise, scl_fall, start_c, stop_c;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      wp_s_r <= 2'h0;
      cs_s_r[0] <= 2'h0;
      cs_s_r[1] <= 2'h0;
      cs_s_r[2] <= 2'h0;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[0], link.scl_o};
      sda_s_r <= {sda_s_r[0], link.sda};
      wp_s_r <= {wp_s_r[0], wp_in};
      cs_s_r[0] <= {cs_s_r[0][0], chip_select_bit_zero};
      cs_s_r[1] <= {cs_s_r[1][0], chip_select_bit_one};
      cs_s_r[2] <= {cs_s_r[2][0], chip_select_bit_two};
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
    end
  end
  assign scl_rise = scl_s_r[1] && !scl_d_r;
  assign scl_fall = !scl_s_r[1] && scl_d_r;
  assign start_c = scl_s_r[1] && scl_d_r && sda_d_r && !sda_s_r[1];
  assign stop_c = scl_s_r[1] && scl_d_r && !sda_d_r && sda_s_r[1];

  // ****************************************
  // Protocol engine
  // ****************************************
  typedef enum {ST_IDLE, ST_CTRL, ST_AHI, ST_ALO, ST_WDATA, ST_RDATA, ST_RACK} eep_st_t;
  eep_st_t st_r, st_nxt;
  logic [7:0] mem_r [4096];
  logic [7:0] page_r [32];
  logic [31:0] pvalid_r, pvalid_nxt;
  logic [7:0] pg_data_nxt;
  logic pg_we;
  logic [11:0] ptr_r, ptr_nxt, base_r, base_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic ack_r, ack_nxt, oe_n_r, oe_n_nxt, wr_cmd_r, wr_cmd_nxt, got_data_r, got_data_nxt;
  logic busy_r, busy_nxt, commit;
  logic [31:0] wcnt_r, wcnt_nxt;
  logic [2:0] cs_now;

  function automatic logic is_prot(input logic [11:0] a, input logic wp);
    is_prot = wp && (a >= eep_pkg::PROT_BASE);
  endfunction

  always_comb begin
    st_nxt = st_r;
    ptr_nxt = ptr_r;
    base_nxt = base_r;
    sh_nxt = sh_r;
    bit_nxt = bit_r;
    ack_nxt = ack_r;
    oe_n_nxt = oe_n_r;
    wr_cmd_nxt = wr_cmd_r;
    got_data_nxt = got_data_r;
    pvalid_nxt = pvalid_r;
    pg_we = 1'b0;
    pg_data_nxt = sh_r;
    busy_nxt = busy_r;
    wcnt_nxt = wcnt_r;
    commit = 1'b0;
    cs_now = {cs_s_r[2][1], cs_s_r[1][1], cs_s_r[0][1]};
    if (busy_r) begin
      if (wcnt_r == 32'(WRITE_CYCLES - 1)) begin
        busy_nxt = 1'b0;
      end else begin
        wcnt_nxt = wcnt_r + 32'h1;
      end
    end
    if (stop_c) begin
      st_nxt = ST_IDLE;
      oe_n_nxt = 1'b1;
      // The protect level is sampled here and nowhere else.
      if (wr_cmd_r && got_data_r && !is_prot(base_r, wp_s_r[1])) begin
        commit = 1'b1;
        busy_nxt = 1'b1;
        wcnt_nxt = 32'h0;
      end
      got_data_nxt = 1'b0;
      wr_cmd_nxt = 1'b0;
    end else if (start_c) begin
      // Repeated Start ends a write without programming.
      st_nxt = ST_CTRL;
      bit_nxt = 4'h0;
      ack_nxt = 1'b0;
      oe_n_nxt = 1'b1;
      wr_cmd_nxt = 1'b0;
      got_data_nxt = 1'b0;
      pvalid_nxt = '0;
    end else if (st_r != ST_IDLE && st_r != ST_RACK && scl_rise && !ack_r) begin
      sh_nxt = {sh_r[6:0], sda_s_r[1]};
      bit_nxt = bit_r + 4'h1;
    end else if (st_r != ST_IDLE && scl_fall) begin
      if (ack_r) begin
        ack_nxt = 1'b0;
        bit_nxt = 4'h0;
        // The first read bit goes out as the control byte's ack slot ends.
        oe_n_nxt = (st_r == ST_RDATA) ? sh_r[7] : 1'b1;
      end else if (st_r == ST_RDATA) begin
        if (bit_r == 4'h8) begin
          oe_n_nxt = 1'b1;
          st_nxt = ST_RACK;
        end else begin
          oe_n_nxt = sh_r[7];
        end
      end else if (bit_r == 4'h8) begin
        ack_nxt = 1'b1;
        oe_n_nxt = 1'b0;
        case (st_r)
          ST_CTRL: begin
            if (sh_r[7:4] != eep_pkg::DEV_CODE || sh_r[3:1] != cs_now || busy_r) begin
              ack_nxt = 1'b0;
              oe_n_nxt = 1'b1;
              st_nxt = ST_IDLE;
            end else if (sh_r[0]) begin
              st_nxt = ST_RDATA;
            end else begin
              st_nxt = ST_AHI;
              wr_cmd_nxt = 1'b1;
            end
          end
          ST_AHI: begin
            ptr_nxt = {sh_r[3:0], ptr_r[7:0]};
            st_nxt = ST_ALO;
          end
          ST_ALO: begin
            ptr_nxt = {ptr_r[11:8], sh_r};
            base_nxt = {ptr_r[11:8], sh_r};
            st_nxt = ST_WDATA;
          end
          ST_WDATA: begin
            pg_we = 1'b1;
            pvalid_nxt[ptr_r[4:0]] = 1'b1;
            got_data_nxt = 1'b1;
            ptr_nxt = {ptr_r[11:5], 5'(ptr_r[4:0] + 5'h1)};
          end
          default: st_nxt = ST_IDLE;
        endcase
      end
    end else if (st_r == ST_RACK && scl_rise) begin
      // The host ack slot decides whether another byte follows.
      ptr_nxt = 12'(ptr_r + 12'h1);
      st_nxt = sda_s_r[1] ? ST_IDLE : ST_RDATA;
    end
    if (st_nxt == ST_RDATA && (st_r != ST_RDATA)) begin
      sh_nxt = mem_r[ptr_nxt];
      bit_nxt = 4'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_r <= ST_IDLE;
      ptr_r <= eep_pkg::ADDR_RST;
      base_r <= eep_pkg::ADDR_RST;
      sh_r <= 8'h00;
      bit_r <= 4'h0;
      ack_r <= 1'b0;
      oe_n_r <= 1'b1;
      wr_cmd_r <= 1'b0;
      got_data_r <= 1'b0;
      pvalid_r <= '0;
      busy_r <= 1'b0;
      wcnt_r <= 32'h0;
    end else begin
      st_r <= st_nxt;
      ptr_r <= ptr_nxt;
      base_r <= base_nxt;
      sh_r <= sh_nxt;
      bit_r <= bit_nxt;
      ack_r <= ack_nxt;
      oe_n_r <= oe_n_nxt;
      wr_cmd_r <= wr_cmd_nxt;
      got_data_r <= got_data_nxt;
      pvalid_r <= pvalid_nxt;
      busy_r <= busy_nxt;
      wcnt_r <= wcnt_nxt;
    end
  end

  // Array and page buffer carry no reset; content is undefined at power-up.
  always_ff @(posedge clk_sys) begin
    if (pg_we) begin
      page_r[ptr_r[4:0]] <= pg_data_nxt;
    end
    if (commit) begin
      for (int i = 0; i < eep_pkg::PAGE_BYTES; i++) begin
        if (pvalid_r[i]) begin
          mem_r[{base_r[11:5], 5'(i)}] <= page_r[i];
        end
      end
    end
  end

  assign link.sda_dev_oe_n = oe_n_r;
  assign busy = busy_r;
  assign addr_ptr = ptr_r;
endmodule
`default_nettype wire

/* logic/eep_host.sv */
// Host end: drives clock and conditions, runs write, pointer and read commands.
`default_nettype none
module eep_host (
  input wire logic clk_sys,
  input wire logic nrst,
  eep_link_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_kind,
  input wire logic [2:0] cmd_sel,
  input wire logic [11:0] cmd_addr,
  input wire logic [5:0] cmd_len,
  input wire logic wd_valid,
  output logic wd_ready,
  input wire logic [7:0] wd_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data,
  output logic nak
);
  typedef enum {H_IDLE, H_START, H_BYTE, H_ACK, H_STOP} eep_hst_t;
  eep_hst_t st_r, st_nxt;
  logic [3:0] div_r, div_nxt;
  logic tick;
  logic [1:0] ph_r, ph_nxt;
  logic scl_r, scl_nxt, oe_n_r, oe_n_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [2:0] step_r, step_nxt;
  logic [5:0] left_r, left_nxt;
  logic [1:0] kind_r, kind_nxt;
  logic [2:0] sel_r, sel_nxt;
  logic [11:0] addr_r, addr_nxt;
  logic rx_r, rx_nxt, nak_r, nak_nxt, bv, br, sda_q;
  logic [1:0] sda_s_r;
  logic [7:0] bd;

  eep_buf2 #(.WIDTH(8)) u_rbuf (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .in_valid(bv),
    .in_ready(br),
    .in_data(bd),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  assign tick = (div_r == 4'(eep_pkg::SCL_HALF - 1));
  assign sda_q = sda_s_r[1];

  always_comb begin
    st_nxt = st_r;
    div_nxt = tick ? 4'h0 : 4'(div_r + 4'h1);
    ph_nxt = ph_r;
    scl_nxt = scl_r;
    oe_n_nxt = oe_n_r;
    sh_nxt = sh_r;
    bit_nxt = bit_r;
    step_nxt = step_r;
    left_nxt = left_r;
    kind_nxt = kind_r;
    sel_nxt = sel_r;
    addr_nxt = addr_r;
    rx_nxt = rx_r;
    nak_nxt = nak_r;
    bv = 1'b0;
    bd = sh_r;
    case (st_r)
      H_IDLE: begin
        if (cmd_valid) begin
          kind_nxt = cmd_kind;
          sel_nxt = cmd_sel;
          addr_nxt = cmd_addr;
          left_nxt = cmd_len;
          step_nxt = 3'h0;
          nak_nxt = 1'b0;
          st_nxt = H_START;
          ph_nxt = 2'h0;
        end
      end
      H_START: if (tick) begin
        ph_nxt = 2'(ph_r + 2'h1);
        if (ph_r == 2'h0) begin
          scl_nxt = 1'b1;
          oe_n_nxt = 1'b1;
        end else if (ph_r == 2'h1) begin
          oe_n_nxt = 1'b0;
        end else begin
          scl_nxt = 1'b0;
          rx_nxt = 1'b0;
          sh_nxt = {eep_pkg::DEV_CODE, sel_r, (kind_r == eep_pkg::EEP_CMD_READ_CUR) || step_r == 3'h4};
          bit_nxt = 4'h0;
          st_nxt = H_BYTE;
          ph_nxt = 2'h0;
        end
      end
      H_BYTE: if (tick) begin
        ph_nxt = 2'(ph_r + 2'h1);
        if (ph_r == 2'h0) begin
          oe_n_nxt = rx_r ? 1'b1 : sh_r[7];
        end else if (ph_r == 2'h1) begin
          scl_nxt = 1'b1;
        end else begin
          scl_nxt = 1'b0;
          sh_nxt = {sh_r[6:0], sda_q};
          bit_nxt = 4'(bit_r + 4'h1);
          ph_nxt = 2'h0;
          if (bit_r == 4'h7) begin
            st_nxt = H_ACK;
          end
        end
      end
      H_ACK: if (tick && (!rx_r || br)) begin
        ph_nxt = 2'(ph_r + 2'h1);
        if (ph_r == 2'h0) begin
          oe_n_nxt = rx_r ? (left_r <= 6'h1) : 1'b1;
        end else if (ph_r == 2'h1) begin
          scl_nxt = 1'b1;
          if (!rx_r && sda_q) begin
            nak_nxt = 1'b1;
          end
        end else begin
          scl_nxt = 1'b0;
          ph_nxt = 2'h0;
          bit_nxt = 4'h0;
          if (rx_r) begin
            bv = 1'b1;
            left_nxt = 6'(left_r - 6'h1);
            st_nxt = (left_r <= 6'h1) ? H_STOP : H_BYTE;
          end else if (nak_r) begin
            st_nxt = H_STOP;
          end else begin
            // Write steps park at the data phase, so long pages never wrap back into the address steps.
            step_nxt = (kind_r == eep_pkg::EEP_CMD_WRITE && step_r == 3'h3) ? step_r : 3'(step_r + 3'h1);
            st_nxt = H_BYTE;
            case (step_r)
              3'h0: sh_nxt = {4'h0, addr_r[11:8]};
              3'h1: sh_nxt = addr_r[7:0];
              3'h4: rx_nxt = 1'b1;
              default: sh_nxt = wd_data;
            endcase
            if (kind_r == eep_pkg::EEP_CMD_READ_CUR && step_r == 3'h0) begin
              rx_nxt = 1'b1;
            end else if (step_r >= 3'h3 && kind_r == eep_pkg::EEP_CMD_WRITE) begin
              if (left_r == 6'h0) begin
                st_nxt = H_STOP;
              end else begin
                left_nxt = 6'(left_r - 6'h1);
                sh_nxt = wd_data;
              end
            end else if (step_r == 3'h2 && kind_r != eep_pkg::EEP_CMD_WRITE) begin
              st_nxt = H_START;
              step_nxt = 3'h4;
            end
          end
        end
      end
      H_STOP: if (tick) begin
        ph_nxt = 2'(ph_r + 2'h1);
        if (ph_r == 2'h0) begin
          oe_n_nxt = 1'b0;
        end else if (ph_r == 2'h1) begin
          scl_nxt = 1'b1;
        end else begin
          oe_n_nxt = 1'b1;
          st_nxt = H_IDLE;
          ph_nxt = 2'h0;
        end
      end
      default: st_nxt = H_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_r <= H_IDLE;
      div_r <= 4'h0;
      ph_r <= 2'h0;
      scl_r <= 1'b1;
      oe_n_r <= 1'b1;
      sh_r <= 8'h00;
      bit_r <= 4'h0;
      step_r <= 3'h0;
      left_r <= 6'h0;
      kind_r <= 2'h0;
      sel_r <= 3'h0;
      addr_r <= 12'h000;
      rx_r <= 1'b0;
      nak_r <= 1'b0;
      sda_s_r <= 2'h3;
    end else begin
      st_r <= st_nxt;
      div_r <= div_nxt;
      ph_r <= ph_nxt;
      scl_r <= scl_nxt;
      oe_n_r <= oe_n_nxt;
      sh_r <= sh_nxt;
      bit_r <= bit_nxt;
      step_r <= step_nxt;
      left_r <= left_nxt;
      kind_r <= kind_nxt;
      sel_r <= sel_nxt;
      addr_r <= addr_nxt;
      rx_r <= rx_nxt;
      nak_r <= nak_nxt;
      sda_s_r <= {sda_s_r[0], link.sda};
    end
  end

  assign cmd_ready = (st_r == H_IDLE);
  assign wd_ready = (st_r == H_ACK) && tick && ph_r == 2'h2 && !rx_r && !nak_r && step_r >= 3'h2;
  assign link.scl_o = scl_r;
  assign link.sda_host_oe_n = oe_n_r;
  assign nak = nak_r;
endmodule
`default_nettype wire

/* sim/eep_link_monitor.sv */
// Concurrent checks on the two-wire link between the client and the host.
`default_nettype none
module eep_link_monitor #(
  parameter int WRITE_CYCLES = 20
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic scl_o,
  input wire logic sda_host_oe_n,
  input wire logic sda_dev_oe_n,
  input wire logic sda,
  input wire logic busy,
  input wire logic [11:0] addr_ptr
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Busy length counter
  // ****************************************
  logic [15:0] busy_cnt_r;
  logic [15:0] busy_cnt_nxt;
  always_comb begin
    busy_cnt_nxt = busy ? busy_cnt_r + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge clk_sys) begin
    busy_cnt_r <= nrst ? busy_cnt_nxt : 16'h0000;
  end
  // ****************************************
  // Assertions
  // ****************************************
  default clocking mon_cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_reset_lines_released: assert property (
    $rose(nrst) |-> scl_o && sda_host_oe_n && sda_dev_oe_n && !busy) else $error("lines not idle after reset");
  a_busy_after_stop: assert property (
    $rose(busy) |-> scl_o && sda) else $error("programming started without a Stop");
  a_busy_cycle_count: assert property (
    $fell(busy) |-> busy_cnt_r == 16'(WRITE_CYCLES)) else $error("programming length wrong");
  a_no_ack_busy: assert property (
    busy |-> sda_dev_oe_n) else $error("client drove the data line while busy");
  a_dev_change_low: assert property (
    $changed(sda_dev_oe_n) |-> !scl_o) else $error("client changed data with clock high");
  a_scl_low_phase: assert property (
    $fell(scl_o) |-> (!scl_o)[*3] ##[1:8] scl_o) else $error("clock low phase wrong");
  a_ptr_frozen_busy: assert property (
    busy && $past(busy) |-> $stable(addr_ptr)) else $error("pointer moved while programming");
  a_stop_released: assert property (
    scl_o && $past(scl_o) && $rose(sda_host_oe_n) |-> sda_dev_oe_n) else $error("client held data at Stop");
  c_write_cycle_done: cover property ($fell(busy));
  c_client_ack: cover property (scl_o && !sda_dev_oe_n);
  c_stop_seen: cover property (scl_o && $past(scl_o) && $rose(sda));
endmodule
`default_nettype wire

/* sim/i2c_eeprom_page_write_read_tb_top.sv */
// Self-checking bench joining the EEPROM client and host over the link.
`default_nettype none
module i2c_eeprom_page_write_read_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Long enough that the first poll always lands inside programming.
  localparam int WCYC = 400;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] sel = 3'h0;
  logic wp_in = 1'b0;
  logic busy;
  logic [11:0] addr_ptr;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  logic [1:0] cmd_kind = 2'h0;
  logic [2:0] cmd_sel = 3'h0;
  logic [11:0] cmd_addr = 12'h000;
  logic [5:0] cmd_len = 6'h00;
  logic wd_valid = 1'b1;
  logic wd_ready;
  logic [7:0] wd_data;
  logic rd_valid;
  logic rd_ready = 1'b0;
  logic [7:0] rd_data;
  logic nak;
  logic [7:0] wbuf [0:63];
  logic [5:0] wptr = 6'h00;
  logic [7:0] exp_mem [0:4095];
  logic [11:0] exp_ptr = 12'h000;
  logic [7:0] rq [$];
  int fail_count = 0;
  int total_checks = 0;
  always #4 clk_sys = ~clk_sys;
  assign wd_data = wbuf[wptr];
  eep_link_if link ();
  eep_client #(.WRITE_CYCLES(WCYC)) i_eep_client (.clk_sys(clk_sys), .nrst(nrst), .link(link),
    .chip_select_bit_two(sel[2]), .chip_select_bit_one(sel[1]), .chip_select_bit_zero(sel[0]),
    .wp_in(wp_in), .busy(busy), .addr_ptr(addr_ptr));
  eep_host i_eep_host (.clk_sys(clk_sys), .nrst(nrst), .link(link), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_sel(cmd_sel), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
    .wd_valid(wd_valid), .wd_ready(wd_ready), .wd_data(wd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_data(rd_data), .nak(nak));
  eep_link_monitor #(.WRITE_CYCLES(WCYC)) i_eep_link_monitor (.clk_sys(clk_sys), .nrst(nrst),
    .scl_o(link.scl_o), .sda_host_oe_n(link.sda_host_oe_n), .sda_dev_oe_n(link.sda_dev_oe_n),
    .sda(link.sda), .busy(busy), .addr_ptr(addr_ptr));
  // The reader stalls about one cycle in four to exercise the read buffer.
  always @(posedge clk_sys) begin
    rd_ready <= ($urandom_range(0, 3) != 0);
    if (wd_ready === 1'b1) wptr <= wptr + 6'h01;
    if (rd_valid === 1'b1 && rd_ready) rq.push_back(rd_data);
  end
  // ****************************************
  // Checking and reporting
  // ****************************************
  task automatic fail(input string msg);
    fail_count++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) fail($sformatf("byte %h, expected %h", got, exp));
  endtask
  task automatic chk12(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) fail($sformatf("pointer %h, expected %h", got, exp));
  endtask
  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) fail($sformatf("flag %b, expected %b", got, exp));
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ****************************************
  // Command drivers
  // ****************************************
  task automatic run_cmd(input logic [1:0] k, input logic [2:0] s, input logic [11:0] a, input logic [5:0] n,
                         input int nrd);
    int t;
    rq.delete();
    @(posedge clk_sys);
    cmd_kind <= k;
    cmd_sel <= s;
    cmd_addr <= a;
    cmd_len <= n;
    cmd_valid <= 1'b1;
    do @(posedge clk_sys); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    t = 0;
    do begin
      @(posedge clk_sys);
      t++;
    end while (cmd_ready !== 1'b1 && t < 20000);
    if (t >= 20000) fail("command never finished");
    t = 0;
    while (nak !== 1'b1 && rq.size() < nrd && t < 400) begin
      @(posedge clk_sys);
      t++;
    end
  endtask
  task automatic do_write(input logic [11:0] a, input int n, input logic [2:0] s, input logic exp_nak);
    for (int i = 0; i < n; i++) wbuf[i] = 8'($urandom);
    wptr <= 6'h00;
    run_cmd(2'h0, s, a, 6'(n - 1), 0);
    chk1(nak, exp_nak);
    if (!exp_nak && !(wp_in && a >= eep_pkg::PROT_BASE)) begin
      for (int i = 0; i < n; i++) exp_mem[{a[11:5], 5'(a[4:0] + i)}] = wbuf[i];
    end
  endtask
  task automatic poll(input logic [11:0] a, input logic exp_busy);
    int tries;
    tries = 0;
    do begin
      run_cmd(2'h1, sel, a, 6'h01, 1);
      tries++;
    end while (nak === 1'b1 && tries < 20);
    chk1(nak, 1'b0);
    chk1(tries > 1, exp_busy);
    chk8(rq.size() > 0 ? rq[0] : 8'hxx, exp_mem[a]);
    exp_ptr = a + 12'h001;
    chk12(addr_ptr, exp_ptr);
  endtask
  task automatic do_read(input logic [1:0] k, input logic [11:0] a, input int n);
    logic [11:0] base;
    base = (k == 2'h2) ? exp_ptr : a;
    run_cmd(k, sel, a, 6'(n), n);
    chk1(nak, 1'b0);
    chk1(busy, 1'b0);
    for (int i = 0; i < n; i++) chk8(rq.size() > i ? rq[i] : 8'hxx, exp_mem[12'(base + i)]);
    exp_ptr = 12'(base + n);
    chk12(addr_ptr, exp_ptr);
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    logic [11:0] ra;
    int rn;
    for (int i = 0; i < 64; i++) wbuf[i] = 8'h00;
    void'($urandom(45));
    sel = 3'($urandom);
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    do_write(12'h000, 32, sel, 1'b0);
    poll(12'h000, 1'b1);
    do_read(2'h2, 12'h000, 31);
    $display("test full page done");
    do_write(12'hfe0, 32, sel, 1'b0);
    poll(12'hffe, 1'b1);
    do_read(2'h2, 12'h000, 3);
    $display("test pointer wrap done");
    do_write(12'h105, 40, sel, 1'b0);
    poll(12'h10d, 1'b1);
    do_read(2'h2, 12'h000, 2);
    $display("test page overrun done");
    for (int j = 0; j < 4; j++) begin
      ra = 12'($urandom_range(0, 12'hbff));
      rn = $urandom_range(1, 32);
      do_write(ra, rn, sel, 1'b0);
      poll(ra, 1'b1);
      do_read(2'h1, ra, (rn < 32 - ra[4:0]) ? rn : 32 - ra[4:0]);
    end
    $display("test random writes done");
    do_write(12'hc40, 4, sel, 1'b0);
    poll(12'hc40, 1'b1);
    wp_in <= 1'b1;
    repeat (4) @(posedge clk_sys);
    do_write(12'hc40, 4, sel, 1'b0);
    poll(12'hc40, 1'b0);
    do_read(2'h1, 12'hc40, 4);
    $display("test protection done");
    wp_in <= 1'b0;
    repeat (4) @(posedge clk_sys);
    do_write(12'hc80, 2, sel, 1'b0);
    // Let the client see the Stop before protect goes high.
    repeat (4) @(posedge clk_sys);
    wp_in <= 1'b1;
    poll(12'hc80, 1'b1);
    do_read(2'h1, 12'hc80, 2);
    wp_in <= 1'b0;
    $display("test protect latch done");
    do_write(12'h200, 1, sel ^ 3'h5, 1'b1);
    chk1(busy, 1'b0);
    $display("test wrong select done");
    wrap_up();
  end
  initial begin
    #800000;
    fail("watchdog expired");
    wrap_up();
  end
endmodule
`default_nettype wire
